/* File: src/dcet_pkg.sv */
// Shared constants and types for the DMA channel event trigger front end
package dcet_pkg;
   // ==========================================
   // Channel counts
   localparam int NUM_DMA = 64;
   localparam int NUM_QK = 8;
   localparam int NUM_CH = 72;
   localparam int NUM_HW = 48;
   localparam int CH_W = 7;
   localparam logic [47:0] HW_RSV_MASK = 48'h0000_0100_3000;
   localparam int ALT_CH0 = 8;
   localparam int ALT_CH1 = 9;
   // ==========================================
   // Channel setting memory layout
   localparam int SET_WORDS = 8;
   localparam int MEM_WORDS = 576;
   localparam int MEM_AW = 10;
   localparam logic [2:0] W_OPT = 3'h0;
   localparam logic [2:0] W_SRC = 3'h1;
   localparam logic [2:0] W_CNT = 3'h2;
   localparam logic [2:0] W_DST = 3'h3;
   localparam logic [2:0] W_STEP = 3'h4;
   localparam logic [2:0] W_LINK = 3'h5;
   localparam logic [2:0] W_TRIG = 3'h7;
   localparam int OPT_SRC_FIX = 0;
   localparam int OPT_DST_FIX = 1;
   localparam int OPT_CHAIN_EN = 2;
   localparam int OPT_TCC_LSB = 8;
   localparam logic [15:0] NULL_LINK = 16'hFFFF;
   localparam int FIX_ALIGN_W = 5;
   localparam int STEP_ALIGN_W = 6;
   // ==========================================
   // Register word addresses
   localparam logic [11:0] A_MAN_LO = 12'h000;
   localparam logic [11:0] A_MAN_HI = 12'h001;
   localparam logic [11:0] A_PEND_LO = 12'h002;
   localparam logic [11:0] A_PEND_HI = 12'h003;
   localparam logic [11:0] A_MASK_LO = 12'h004;
   localparam logic [11:0] A_MASK_HI = 12'h005;
   localparam logic [11:0] A_MISS_LO = 12'h006;
   localparam logic [11:0] A_MISS_HI = 12'h007;
   localparam logic [11:0] A_CHAIN_LO = 12'h008;
   localparam logic [11:0] A_CHAIN_HI = 12'h009;
   localparam logic [11:0] A_QK_EN = 12'h00A;
   localparam logic [11:0] A_QK_PEND = 12'h00B;
   localparam logic [11:0] A_QK_MISS = 12'h00C;
   localparam logic [11:0] A_LINK_COPY = 12'h00D;
   localparam logic [11:0] A_STATUS = 12'h00E;
   localparam logic [11:0] A_MEM_BASE = 12'h400;
   // ==========================================
   // Queue and timing
   localparam int QDEPTH = 16;
   localparam int QPTR_W = 5;
   localparam int CLK_NS = 20;
   localparam int XFER_TIME_NS = 200;
   localparam int XFER_CYC = XFER_TIME_NS / CLK_NS;

   typedef struct packed {
      logic [6:0] chan;
      logic [31:0] opt;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] cnt;
      logic [31:0] step;
      logic [31:0] frames;
   } dcet_packet_t;
endpackage

/* File: src/dcet_if.sv */
// Link between the channel controller and the transfer controller side
interface dcet_if;
   logic [47:0] evt_line;
   logic [1:0] evt_alt;
   logic alt_sel;
   logic req_valid;
   logic req_ready;
   dcet_pkg::dcet_packet_t req_pkt;
   logic done_valid;
   logic [5:0] done_code;
   modport cc (input evt_line, input evt_alt, input alt_sel, input req_ready,
      input done_valid, input done_code, output req_valid, output req_pkt);
   modport tc (output evt_line, output evt_alt, output alt_sel, output req_ready,
      output done_valid, output done_code, input req_valid, input req_pkt);
endinterface

/* File: src/dcet_xfer_ctrl.sv */
// Transfer controller end: peripheral event drive, request intake, completion
module dcet_xfer_ctrl (
   input wire logic core_clk,
   input wire logic rst_b,
   dcet_if.tc link,
   input wire logic [47:0] periph_evt,
   input wire logic [1:0] periph_alt,
   input wire logic alt_cfg,
   input wire logic err_clr,
   output logic xfer_err,
   output logic [6:0] err_chan,
   output logic busy
);
   import dcet_pkg::*;
   typedef enum logic {TC_IDLE, TC_BUSY} dcet_tc_state_t;

   dcet_tc_state_t state_q;
   logic [7:0] cnt_q;
   logic [5:0] code_q;
   logic chain_q;
   logic err_q;
   logic [6:0] err_chan_q;
   logic [47:0] evt_q;
   logic [1:0] alt_q;
   logic alt_sel_q;
   logic done_q;

   // ==========================================
   // Alignment check on constant-address sides
   wire take = link.req_valid && (state_q == TC_IDLE);
   wire [31:0] p_opt = link.req_pkt.opt;
   wire src_bad = p_opt[OPT_SRC_FIX] && ((link.req_pkt.src[FIX_ALIGN_W-1:0] != '0) ||
      (link.req_pkt.step[STEP_ALIGN_W-1:0] != '0));
   wire dst_bad = p_opt[OPT_DST_FIX] && ((link.req_pkt.dst[FIX_ALIGN_W-1:0] != '0) ||
      (link.req_pkt.step[16+STEP_ALIGN_W-1:16] != '0));
   wire bad = take && (src_bad || dst_bad);

   assign link.req_ready = (state_q == TC_IDLE);
   assign link.evt_line = evt_q;
   assign link.evt_alt = alt_q;
   assign link.alt_sel = alt_sel_q;
   assign link.done_valid = done_q;
   assign link.done_code = code_q;
   assign xfer_err = err_q;
   assign err_chan = err_chan_q;
   assign busy = (state_q == TC_BUSY);

   // ==========================================
   // Request intake and completion timer
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= TC_IDLE;
         cnt_q <= 8'h00;
         code_q <= 6'h00;
         chain_q <= 1'b0;
         err_q <= 1'b0;
         err_chan_q <= 7'h00;
         evt_q <= 48'h0;
         alt_q <= 2'h0;
         alt_sel_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         evt_q <= periph_evt;
         alt_q <= periph_alt;
         alt_sel_q <= alt_cfg;
         done_q <= 1'b0;
         // Set wins over clear so an error in the clear cycle is kept
         err_q <= (err_q && !err_clr) || bad;
         if (bad) begin
            err_chan_q <= link.req_pkt.chan;
         end
         unique case (state_q)
            TC_IDLE: begin
               if (take) begin
                  state_q <= TC_BUSY;
                  cnt_q <= 8'(XFER_CYC - 1);
                  code_q <= p_opt[OPT_TCC_LSB +: 6];
                  chain_q <= p_opt[OPT_CHAIN_EN];
               end
            end
            TC_BUSY: begin
               if (cnt_q == 8'h00) begin
                  state_q <= TC_IDLE;
                  done_q <= chain_q;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
         endcase
      end
   end
endmodule

/* File: src/dcet_chan_ctrl.sv */
// Channel controller end: event latching, triggers, queue and request issue
// ==========================================
// Notes on behaviour
// - Constant address needs 256-bit alignment
// - Programmer sets step to multiple of 64
// - Alignment faults flagged downstream, never here
// - Constant mode only for fixed-address endpoints
// - Transfers defined by three counts
// - Hardware, manual and chained trigger sources
// - Manual trigger bit write raises trigger
// - Completion with chaining triggers target channel
// - Quick channel triggers on trigger word write
// - Link reload of quick set triggers it
// - Hardware event sets pending bit
// - Enabled pending event gets queued
// - Only queue head is evaluated
// - Non-null set: send packet, clear pending
// - Null set: no packet, clear, mark missed
// - Software clears missed flag before retrigger
// - Pending set regardless of enable mask
// - Held pending event served once enabled
// - Repeat event while pending marks missed
// - Fixed event map, channels 12,13,24 unused
// - Channels 8 and 9 choose alternate source
// - Null set: zeros with link FFFF
//
// The address-and-strobe port and the placing of the registers were decided locally.
module dcet_chan_ctrl (
   input wire logic core_clk,
   input wire logic rst_b,
   dcet_if.cc link,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import dcet_pkg::*;
   typedef enum logic {ST_IDLE, ST_SEND} dcet_cc_state_t;

   // Lowest set bit; keeps service order deterministic
   function automatic logic [7:0] lowest(input logic [NUM_CH-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 7'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [NUM_CH-1:0] onehot(input logic [6:0] c);
      return NUM_CH'(1) << c;
   endfunction

   // ==========================================
   // Pin synchronisers for the event lines
   logic [49:0] s1_q, s2_q, s3_q, filt_q;
   wire [49:0] rise = s2_q & s3_q & ~filt_q;
   wire [63:0] hw_evt;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
      end else begin
         s1_q <= {link.evt_alt, link.evt_line};
         s2_q <= s1_q;
         s3_q <= s2_q;
         // A change counts only once stages two and three agree
         filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
      end
   end

   for (genvar i = 0; i < NUM_DMA; i++) begin : g_map
      if (i >= NUM_HW || HW_RSV_MASK[i % NUM_HW]) begin : g_none
         assign hw_evt[i] = 1'b0;
      end else if (i == ALT_CH0 || i == ALT_CH1) begin : g_alt
         assign hw_evt[i] = link.alt_sel ? rise[NUM_HW + i - ALT_CH0] : rise[i];
      end else begin : g_pin
         assign hw_evt[i] = rise[i];
      end
   end

   // ==========================================
   // State
   logic [31:0] mem_q [MEM_WORDS];
   logic [63:0] er_q, esr_q, cer_q, mask_q;
   logic [7:0] qer_q, qen_q;
   logic [NUM_CH-1:0] miss_q, inq_q;
   logic [6:0] fifo_q [QDEPTH];
   logic [QPTR_W-1:0] wp_q, rp_q;
   dcet_cc_state_t state_q;
   dcet_packet_t pkt_q;
   logic [31:0] rdata_q;

   // ==========================================
   // Register decode
   wire wr_man_lo = reg_wr && reg_addr == A_MAN_LO;
   wire wr_man_hi = reg_wr && reg_addr == A_MAN_HI;
   wire wr_lk = reg_wr && reg_addr == A_LINK_COPY;
   wire mem_sel = reg_addr >= A_MEM_BASE && reg_addr < A_MEM_BASE + 12'(MEM_WORDS);
   wire [MEM_AW-1:0] mem_idx = MEM_AW'(reg_addr - A_MEM_BASE);
   wire wr_mem = reg_wr && mem_sel;
   wire [6:0] lk_src = reg_wdata[6:0];
   wire [6:0] lk_dst = reg_wdata[22:16];
   wire lk_ok = wr_lk && lk_src < 7'(NUM_CH) && lk_dst < 7'(NUM_CH);
   wire [63:0] man_set = {wr_man_hi ? reg_wdata : 32'h0, wr_man_lo ? reg_wdata : 32'h0};
   wire [63:0] chain_set = link.done_valid ? 64'(onehot({1'b0, link.done_code})) : 64'h0;
   wire [NUM_CH-1:0] miss_w1c = {reg_wr && reg_addr == A_QK_MISS ? reg_wdata[7:0] : 8'h00,
      reg_wr && reg_addr == A_MISS_HI ? reg_wdata : 32'h0,
      reg_wr && reg_addr == A_MISS_LO ? reg_wdata : 32'h0};
   logic [7:0] qk_trig;

   for (genvar q = 0; q < NUM_QK; q++) begin : g_qk
      wire sw_hit = wr_mem && mem_idx[2:0] == W_TRIG && mem_idx[9:3] == 7'(NUM_DMA + q);
      wire lk_hit = lk_ok && lk_dst == 7'(NUM_DMA + q);
      assign qk_trig[q] = qen_q[q] && (sw_hit || lk_hit);
   end

   // ==========================================
   // Queue selection and head evaluation
   wire [63:0] dma_qual = (er_q & mask_q) | esr_q | cer_q;
   wire [7:0] pick = lowest({qer_q, dma_qual} & ~inq_q);
   wire q_empty = wp_q == rp_q;
   wire q_full = wp_q == {~rp_q[QPTR_W-1], rp_q[QPTR_W-2:0]};
   wire push = pick[7] && !q_full;
   wire [6:0] head = fifo_q[rp_q[QPTR_W-2:0]];
   wire [9:0] hb = {head, 3'h0};
   logic head_null;

   always_comb begin
      head_null = mem_q[hb + 10'(W_LINK)] == {16'h0, NULL_LINK};
      for (int w = 0; w < SET_WORDS; w++) begin
         if (w != int'(W_LINK) && mem_q[hb + 10'(w)] != 32'h0) begin
            head_null = 1'b0;
         end
      end
   end

   wire idle_eval = state_q == ST_IDLE && !q_empty;
   wire null_pop = idle_eval && head_null;
   wire sent = state_q == ST_SEND && link.req_ready;
   wire pop = null_pop || sent;
   wire [NUM_CH-1:0] clr = pop ? onehot(head) : '0;
   wire [NUM_CH-1:0] dup = {qk_trig & qer_q, (hw_evt & er_q) | (man_set & esr_q) |
      (chain_set & cer_q)};
   wire [NUM_CH-1:0] miss_set = dup | (null_pop ? onehot(head) : '0);

   assign link.req_valid = state_q == ST_SEND;
   assign link.req_pkt = pkt_q;
   assign reg_rdata = rdata_q;

   // ==========================================
   // Event latches; a same-cycle clear wins, a new event on a still-set bit only marks missed
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         er_q <= '0;
         esr_q <= '0;
         cer_q <= '0;
         qer_q <= '0;
         miss_q <= '0;
         inq_q <= '0;
      end else begin
         er_q <= (er_q & ~clr[63:0]) | (hw_evt & ~er_q);
         esr_q <= (esr_q & ~clr[63:0]) | (man_set & ~esr_q);
         cer_q <= (cer_q & ~clr[63:0]) | (chain_set & ~cer_q);
         qer_q <= (qer_q & ~clr[71:64]) | (qk_trig & ~qer_q);
         miss_q <= (miss_q & ~miss_w1c) | miss_set;
         inq_q <= (inq_q & ~clr) | (push ? onehot(pick[6:0]) : '0);
      end
   end

   // ==========================================
   // Queue storage and request issue
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_q <= '0;
         rp_q <= '0;
         state_q <= ST_IDLE;
         pkt_q <= '0;
         for (int i = 0; i < QDEPTH; i++) begin
            fifo_q[i] <= 7'h00;
         end
      end else begin
         if (push) begin
            fifo_q[wp_q[QPTR_W-2:0]] <= pick[6:0];
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         unique case (state_q)
            ST_IDLE: begin
               if (idle_eval && !head_null) begin
                  state_q <= ST_SEND;
                  pkt_q.chan <= head;
                  pkt_q.opt <= mem_q[hb + 10'(W_OPT)];
                  pkt_q.src <= mem_q[hb + 10'(W_SRC)];
                  pkt_q.dst <= mem_q[hb + 10'(W_DST)];
                  pkt_q.cnt <= mem_q[hb + 10'(W_CNT)];
                  pkt_q.step <= mem_q[hb + 10'(W_STEP)];
                  pkt_q.frames <= mem_q[hb + 10'(W_TRIG)];
               end
            end
            ST_SEND: begin
               if (link.req_ready) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================
   // Software registers and channel setting memory
   // Constant-mode fields go out unchecked; the far end judges them
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= '0;
         qen_q <= '0;
         rdata_q <= '0;
         for (int i = 0; i < MEM_WORDS; i++) begin
            mem_q[i] <= (i % SET_WORDS == int'(W_LINK)) ? {16'h0, NULL_LINK} : 32'h0;
         end
      end else begin
         if (reg_wr && reg_addr == A_MASK_LO) begin
            mask_q[31:0] <= reg_wdata;
         end
         if (reg_wr && reg_addr == A_MASK_HI) begin
            mask_q[63:32] <= reg_wdata;
         end
         if (reg_wr && reg_addr == A_QK_EN) begin
            qen_q <= reg_wdata[7:0];
         end
         if (wr_mem) begin
            mem_q[mem_idx] <= reg_wdata;
         end
         if (lk_ok) begin
            for (int w = 0; w < SET_WORDS; w++) begin
               mem_q[{lk_dst, 3'(w)}] <= mem_q[{lk_src, 3'(w)}];
            end
         end
         rdata_q <= 32'h0;
         if (reg_rd) begin
            unique case (reg_addr)
               A_PEND_LO: rdata_q <= er_q[31:0];
               A_PEND_HI: rdata_q <= er_q[63:32];
               A_MASK_LO: rdata_q <= mask_q[31:0];
               A_MASK_HI: rdata_q <= mask_q[63:32];
               A_MISS_LO: rdata_q <= miss_q[31:0];
               A_MISS_HI: rdata_q <= miss_q[63:32];
               A_CHAIN_LO: rdata_q <= cer_q[31:0];
               A_CHAIN_HI: rdata_q <= cer_q[63:32];
               A_QK_EN: rdata_q <= {24'h0, qen_q};
               A_QK_PEND: rdata_q <= {24'h0, qer_q};
               A_QK_MISS: rdata_q <= {24'h0, miss_q[71:64]};
               A_STATUS: rdata_q <= {26'h0, state_q == ST_SEND, wp_q - rp_q};
               default: rdata_q <= mem_sel ? mem_q[mem_idx] : 32'h0;
            endcase
         end
      end
   end
endmodule

/* File: sim/dcet_assertions.sv */
// Checker on the link between the channel controller and transfer controller
module dcet_assertions (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire dcet_pkg::dcet_packet_t req_pkt,
   input wire logic done_valid,
   input wire logic [5:0] done_code
);
   timeunit 1ns;
   timeprecision 1ps;
   import dcet_pkg::*;
   // ==========================================
   // Helper state: code and age of the last taken request
   logic take;
   logic [5:0] code_q;
   logic [4:0] since_q;
   assign take = req_valid && req_ready;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         code_q <= 6'h00;
         since_q <= 5'h1F;
      end else if (take) begin
         code_q <= req_pkt.opt[OPT_TCC_LSB +: 6];
         since_q <= 5'h00;
      end else if (since_q != 5'h1F) begin
         since_q <= since_q + 5'h01;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================
   // Assertions
   req_hold_a: assert property (req_valid && !req_ready |=>
      req_valid && $stable(req_pkt))
      else $error("request dropped or changed before it was taken");
   req_drop_a: assert property (take |=> !req_valid)
      else $error("request still offered after it was taken");
   tc_busy_a: assert property (take |=> !req_ready)
      else $error("transfer side ready right after a take");
   tc_free_a: assert property ($fell(req_ready) |-> ##[1:12] req_ready)
      else $error("transfer side never became ready again");
   chain_done_a: assert property (take && req_pkt.opt[OPT_CHAIN_EN] |=>
      ##[9:10] (done_valid && done_code == code_q))
      else $error("chained completion missing or wrong code");
   done_pulse_a: assert property (done_valid |=> !done_valid)
      else $error("completion pulse longer than one cycle");
   done_cause_a: assert property (done_valid |-> since_q inside {[5'h09:5'h0B]})
      else $error("completion without a matching taken request");
   chan_range_a: assert property (req_valid |-> req_pkt.chan < 7'(NUM_CH))
      else $error("request for a channel that does not exist");
   // Main scenarios reached
   cover property (take);
   cover property (take && req_pkt.opt[OPT_CHAIN_EN]);
   cover property (take && req_pkt.chan >= 7'(NUM_DMA));
endmodule

/* File: sim/dcet_tb.sv */
// Testbench joining both ends of the channel event trigger link
module dcet_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dcet_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [47:0] periph_evt = 48'h0;
   logic [1:0] periph_alt = 2'h0;
   logic alt_cfg = 1'b0;
   logic err_clr = 1'b0;
   logic xfer_err;
   logic [6:0] err_chan;
   logic tc_busy;
   logic took = 1'b0;
   logic [6:0] log_ch[$];
   logic [31:0] last_cnt;
   int fail_count = 0;
   int n_compared = 0;
   dcet_if lnk ();
   dcet_chan_ctrl dcet_chan_ctrl_inst (.core_clk(core_clk), .rst_b(rst_b), .link(lnk),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   dcet_xfer_ctrl dcet_xfer_ctrl_inst (.core_clk(core_clk), .rst_b(rst_b), .link(lnk),
      .periph_evt(periph_evt), .periph_alt(periph_alt), .alt_cfg(alt_cfg),
      .err_clr(err_clr), .xfer_err(xfer_err), .err_chan(err_chan), .busy(tc_busy));
   dcet_assertions dcet_assertions_inst (.core_clk(core_clk), .rst_b(rst_b),
      .req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_pkt(lnk.req_pkt),
      .done_valid(lnk.done_valid), .done_code(lnk.done_code));
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   // ==========================================
   // Log of every request taken on the link
   // Transfer side must show busy on the cycle after every take
   always @(posedge core_clk) begin
      if (took) begin
         chk("tc_busy", {31'h0, tc_busy}, 32'h1);
      end
      took = lnk.req_valid === 1'b1 && lnk.req_ready === 1'b1;
      if (took) begin
         log_ch.push_back(lnk.req_pkt.chan);
         last_cnt = lnk.req_pkt.cnt;
      end
   end
   // ==========================================
   // Access tasks
   function automatic logic [11:0] ma(input int ch, input int w);
      return A_MEM_BASE + 12'(ch * SET_WORDS + w);
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rc(input string what, input logic [11:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(what, reg_rdata, exp);
   endtask
   // Source word is deliberately off a 32-byte boundary
   task automatic prog(input int ch, input logic [31:0] opt);
      wr(ma(ch, 0), opt);
      wr(ma(ch, 1), 32'h0000_1004);
      wr(ma(ch, 2), 32'h0004_0010);
   endtask
   // Held long enough to clear the event line synchronisers
   task automatic pulse(input int i);
      @(posedge core_clk);
      if (i < NUM_HW) periph_evt[i] <= 1'b1;
      else periph_alt[i - NUM_HW] <= 1'b1;
      repeat (4) @(posedge core_clk);
      periph_evt <= 48'h0;
      periph_alt <= 2'h0;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic wait_log(input int n);
      int k;
      k = 0;
      while (log_ch.size() < n && k < 400) begin
         @(posedge core_clk);
         k++;
      end
      repeat (14) @(posedge core_clk);
   endtask
   task automatic endt(input string s);
      $display("test %s done, mismatches so far %0d", s, fail_count);
   endtask
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      rc("pend_reset", A_PEND_LO, 32'h0);
      rc("null_link", ma(3, 5), 32'h0000_FFFF);
      rc("status_reset", A_STATUS, 32'h0);
      endt("reset");
      wr(A_MAN_LO, 32'h8);
      repeat (8) @(posedge core_clk);
      chk("null_no_req", 32'(log_ch.size()), 32'h0);
      rc("null_miss", A_MISS_LO, 32'h8);
      wr(A_MISS_LO, 32'h8);
      rc("miss_clear", A_MISS_LO, 32'h0);
      endt("null set");
      prog(5, 32'h0);
      pulse(5);
      rc("pend_masked", A_PEND_LO, 32'h20);
      pulse(5);
      rc("miss_repeat", A_MISS_LO, 32'h20);
      chk("masked_no_req", 32'(log_ch.size()), 32'h0);
      wr(A_MASK_LO, 32'h20);
      wait_log(1);
      chk("held_chan", 32'(log_ch[0]), 32'h5);
      chk("three_counts", last_cnt, 32'h0004_0010);
      rc("pend_served", A_PEND_LO, 32'h0);
      rc("miss_sticky", A_MISS_LO, 32'h20);
      wr(A_MISS_LO, 32'h20);
      endt("hardware event");
      log_ch.delete();
      prog(2, 32'h0000_0704);
      prog(4, 32'h0);
      prog(7, 32'h0);
      wr(A_MAN_LO, 32'h14);
      wait_log(3);
      chk("first_low", 32'(log_ch[0]), 32'h2);
      chk("second", 32'(log_ch[1]), 32'h4);
      chk("chained", 32'(log_ch[2]), 32'h7);
      endt("order and chain");
      alt_cfg <= 1'b1;
      pulse(48);
      alt_cfg <= 1'b0;
      pulse(9);
      pulse(12);
      rc("alt_and_reserved", A_PEND_LO, 32'h300);
      endt("event map");
      log_ch.delete();
      wr(A_QK_EN, 32'h1);
      prog(64, 32'h0);
      wr(ma(64, 7), 32'h1);
      wait_log(1);
      prog(70, 32'h0);
      wr(A_LINK_COPY, 32'h0040_0046);
      wait_log(2);
      chk("quick_auto", 32'(log_ch[0]), 32'h40);
      chk("quick_link", 32'(log_ch[1]), 32'h40);
      wr(ma(64, 7), 32'h1);
      wr(ma(64, 7), 32'h1);
      rc("quick_miss", A_QK_MISS, 32'h1);
      wr(A_QK_MISS, 32'h1);
      rc("quick_miss_clr", A_QK_MISS, 32'h0);
      endt("quick channel");
      prog(10, 32'h1);
      wr(A_MAN_LO, 32'h400);
      wait_log(4);
      chk("const_sent", 32'(log_ch[3]), 32'h0A);
      chk("const_err", {31'h0, xfer_err}, 32'h1);
      chk("err_chan", {25'h0, err_chan}, 32'h0A);
      err_clr <= 1'b1;
      @(posedge core_clk);
      err_clr <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("err_cleared", {31'h0, xfer_err}, 32'h0);
      endt("constant address");
      results();
   end
   // Whole run needs a few hundred cycles; this bound only cuts a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      results();
   end
endmodule
